// *** bench/rld_rotate_left_datapath_test.sv ***
`timescale 1ns/1ps
module rld_rotate_left_datapath_test;
	logic                 clock;
	logic                 rst;
	rld_pkg::rld_instr_s  instr;
	logic [7:0]           fileReadData;
	logic                 carryIn;
	logic                 carryLoad;
	logic [15:0]          stackTopValue;
	logic                 programCounterLowRead;
	logic [7:0]           fileReadAddr;
	rld_pkg::rld_fwrite_s fileWrite;
	logic [7:0]           workingRegister;
	logic                 carry;
	logic [15:0]          programCounter;
	logic [7:0]           programCounterHighLatch;
	logic                 busy;
	logic                 done;
	int                   numErrors;
	int                   numChecks;
	int                   cycles = 0;
	logic [7:0]           wExp;

	rld_rotate_left_datapath uut (
		.clock                   (clock),
		.rst                     (rst),
		.instr                   (instr),
		.fileReadData            (fileReadData),
		.carryIn                 (carryIn),
		.carryLoad               (carryLoad),
		.stackTopValue           (stackTopValue),
		.programCounterLowRead   (programCounterLowRead),
		.fileReadAddr            (fileReadAddr),
		.fileWrite               (fileWrite),
		.workingRegister         (workingRegister),
		.carry                   (carry),
		.programCounter          (programCounter),
		.programCounterHighLatch (programCounterHighLatch),
		.busy                    (busy),
		.done                    (done)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic summarize;
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Eight rising edges span two Q1-to-Q1 cycles, so phases stay aligned
	task automatic exec(input logic [15:0] w, input logic [7:0] f, input logic cin);
		logic       isRlc;
		logic       isRot;
		logic       isRet;
		logic [7:0] res;
		int         doneCount;
		isRlc = (w[15:9] == rld_pkg::OPC_RLC);
		isRot = isRlc || (w[15:9] == rld_pkg::OPC_RLNC);
		isRet = (w == rld_pkg::OPC_RETURN);
		res = isRlc ? {f[6:0], cin} : {f[6:0], f[7]};
		doneCount = 0;
		instr <= '{word: w, valid: 1'b1};
		fileReadData <= f;
		carryIn <= cin;
		carryLoad <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			@(posedge clock);
			instr.valid <= 1'b0;
			carryLoad <= 1'b0;
			@(negedge clock);
			if (i == 0) check(busy, 1'b1);
			if (i == 3) check(busy, 1'b0);
			if (i == 1 && isRot) check(fileReadAddr, w[7:0]);
			if (done === 1'b1) begin
				doneCount++;
				if (isRot && w[8]) begin
					check(fileWrite.we, 1'b1);
					check(fileWrite.addr, w[7:0]);
					check(fileWrite.data, res);
					check(workingRegister, wExp);
				end else if (isRot) begin
					check(fileWrite.we, 1'b0);
					check(workingRegister, res);
					wExp = res;
				end
				if (isRot) check(carry, isRlc ? f[7] : cin);
				if (isRet) check(programCounter, stackTopValue);
			end
		end
		check(doneCount, (isRot || isRet) ? 1 : 0);
		check(workingRegister, wExp);
		@(posedge clock);
	endtask

	task automatic readLow(input logic [7:0] exp);
		programCounterLowRead <= 1'b1;
		@(posedge clock);
		programCounterLowRead <= 1'b0;
		@(negedge clock);
		check(programCounterHighLatch, exp);
		repeat (3) @(posedge clock);
	endtask

	task automatic testNoCarry;
		exec({rld_pkg::OPC_RLNC, 1'b1, 8'hFF}, 8'hEB, 1'b0);
		exec({rld_pkg::OPC_RLNC, 1'b0, 8'h00}, 8'h80, 1'b1);
	endtask

	task automatic testThroughCarry;
		exec({rld_pkg::OPC_RLC, 1'b0, 8'h00}, 8'hE6, 1'b0);
		exec({rld_pkg::OPC_RLC, 1'b1, 8'hFF}, 8'h35, 1'b1);
	endtask

	task automatic testReturn;
		stackTopValue <= 16'hA5C3;
		exec(rld_pkg::OPC_RETURN, 8'h00, 1'b0);
		readLow(8'hA5);
		stackTopValue <= 16'h3C10;
		exec(rld_pkg::OPC_RETURN, 8'h00, 1'b1);
		readLow(8'h3C);
	endtask

	task automatic testUnknown;
		exec(16'h2400, 8'h5A, 1'b0);
		exec(16'h1800, 8'h5A, 1'b1);
		exec(16'h0003, 8'h5A, 1'b0);
	endtask

	// Hang guard, generous against roughly 100 cycles of tests
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			numErrors++;
			summarize();
		end
	end

	initial begin
		numErrors = 0;
		numChecks = 0;
		wExp = rld_pkg::WORKING_REG_RST;
		rst = 1'b1;
		instr = '{word: 16'h0000, valid: 1'b0};
		fileReadData = 8'h00;
		carryIn = 1'b0;
		carryLoad = 1'b0;
		stackTopValue = 16'h0000;
		programCounterLowRead = 1'b0;
		repeat (19) @(posedge clock);
		@(negedge clock);
		check(workingRegister, rld_pkg::WORKING_REG_RST);
		check(programCounter, rld_pkg::PC_RST);
		check(carry, 1'b0);
		check(done, 1'b0);
		check(busy, 1'b0);
		check(fileWrite.we, 1'b0);
		@(posedge clock);
		rst <= 1'b0;
		testNoCarry();
		testThroughCarry();
		testUnknown();
		testReturn();
		summarize();
	end
endmodule

// *** core/rld_pkg.sv ***
package rld_pkg;

	// Opcode field layout, operand MSB and PC high byte slice
	localparam int OP_HI = 15;
	localparam int OP_LO = 9;
	localparam int DEST_BIT = 8;
	localparam int ADDR_HI = 7;
	localparam int MSB = 7;
	localparam int PCH_HI = 15;
	localparam int PCH_LO = 8;

	localparam logic [6:0] OPC_RLNC = 7'h11;
	localparam logic [6:0] OPC_RLC = 7'h0D;
	localparam logic [15:0] OPC_RETURN = 16'h0002;

	localparam logic [7:0] WORKING_REG_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;

	typedef enum logic [1:0] {
		RLD_Q1 = 2'b00,
		RLD_Q2 = 2'b01,
		RLD_Q3 = 2'b10,
		RLD_Q4 = 2'b11
	} rld_phase_e;

	typedef enum logic [1:0] {
		RLD_OP_NONE = 2'b00,
		RLD_OP_RLNC = 2'b01,
		RLD_OP_RLC  = 2'b10,
		RLD_OP_RET  = 2'b11
	} rld_op_e;

	// Instruction word presented to the datapath
	typedef struct packed {
		logic [15:0] word;
		logic        valid;
	} rld_instr_s;

	// File register write port
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic       we;
	} rld_fwrite_s;

	typedef struct packed {
		rld_phase_e  phase;
		rld_op_e     op;
		logic        dest;
		logic [7:0]  addr;
		logic [7:0]  operand;
		logic [7:0]  result;
		logic        carryOut;
		logic        carry;
		logic [7:0]  workingRegister;
		logic [15:0] pc;
		logic [7:0]  pcHighLatch;
		logic [7:0]  fileReadAddr;
		rld_fwrite_s fileWrite;
		logic        busy;
		logic        done;
	} rld_state_s;

endpackage

// *** core/rotate_left_datapath.sv ***
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module rld_rotate_left_datapath (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire rld_pkg::rld_instr_s  instr,
	input  wire logic [7:0]           fileReadData,
	input  wire logic                 carryIn,
	input  wire logic                 carryLoad,
	input  wire logic [15:0]          stackTopValue,
	input  wire logic                 programCounterLowRead,
	output logic [7:0]                fileReadAddr,
	output rld_pkg::rld_fwrite_s      fileWrite,
	output logic [7:0]                workingRegister,
	output logic                      carry,
	output logic [15:0]               programCounter,
	output logic [7:0]                programCounterHighLatch,
	output logic                      busy,
	output logic                      done
);

	rld_pkg::rld_state_s state;
	rld_pkg::rld_state_s next_state;

	function automatic rld_pkg::rld_op_e decode(input logic [15:0] w);
		if (w == rld_pkg::OPC_RETURN) begin
			decode = rld_pkg::RLD_OP_RET;
		end else if (w[rld_pkg::OP_HI:rld_pkg::OP_LO] == rld_pkg::OPC_RLNC) begin
			decode = rld_pkg::RLD_OP_RLNC;
		end else if (w[rld_pkg::OP_HI:rld_pkg::OP_LO] == rld_pkg::OPC_RLC) begin
			decode = rld_pkg::RLD_OP_RLC;
		end else begin
			decode = rld_pkg::RLD_OP_NONE;
		end
	endfunction

	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		next_state.fileWrite.we = 1'b0;
		// Carry is owned by the status logic outside except during our write
		if (carryLoad) begin
			next_state.carry = carryIn;
		end
		// Low byte read refreshes high latch
		// latch from PC
		if (programCounterLowRead) begin
			next_state.pcHighLatch = state.pc[rld_pkg::PCH_HI:rld_pkg::PCH_LO];
		end
		case (state.phase)
			rld_pkg::RLD_Q1: begin
				next_state.op = instr.valid ? decode(instr.word) : rld_pkg::RLD_OP_NONE;
				next_state.dest = instr.word[rld_pkg::DEST_BIT];
				next_state.addr = instr.word[rld_pkg::ADDR_HI:0];
				next_state.fileReadAddr = instr.word[rld_pkg::ADDR_HI:0];
				next_state.busy = instr.valid;
				next_state.phase = rld_pkg::RLD_Q2;
			end
			rld_pkg::RLD_Q2: begin
				next_state.operand = fileReadData;
				next_state.phase = rld_pkg::RLD_Q3;
			end
			rld_pkg::RLD_Q3: begin
				case (state.op)
					rld_pkg::RLD_OP_RLNC: begin
						next_state.result = {state.operand[rld_pkg::MSB-1:0], state.operand[rld_pkg::MSB]};
						next_state.carryOut = state.carry;
					end
					rld_pkg::RLD_OP_RLC: begin
						next_state.result = {state.operand[rld_pkg::MSB-1:0], state.carry};
						next_state.carryOut = state.operand[rld_pkg::MSB];
					end
					default: begin
						next_state.result = state.operand;
						next_state.carryOut = state.carry;
					end
				endcase
				next_state.phase = rld_pkg::RLD_Q4;
			end
			rld_pkg::RLD_Q4: begin
				case (state.op)
					rld_pkg::RLD_OP_RLNC, rld_pkg::RLD_OP_RLC: begin
						if (state.dest) begin
							next_state.fileWrite.we = 1'b1;
							next_state.fileWrite.addr = state.addr;
							next_state.fileWrite.data = state.result;
						end else begin
							next_state.workingRegister = state.result;
						end
						if (state.op == rld_pkg::RLD_OP_RLC) begin
							next_state.carry = state.carryOut;
						end
						next_state.done = 1'b1;
					end
					rld_pkg::RLD_OP_RET: begin
						next_state.pc = stackTopValue;
						next_state.done = 1'b1;
					end
					default: begin
						next_state.done = 1'b0;
					end
				endcase
				next_state.busy = 1'b0;
				next_state.phase = rld_pkg::RLD_Q1;
			end
			default: begin
				next_state.phase = rld_pkg::RLD_Q1;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= '0;
			state.phase <= rld_pkg::RLD_Q1;
			state.op <= rld_pkg::RLD_OP_NONE;
			state.workingRegister <= rld_pkg::WORKING_REG_RST;
			state.pc <= rld_pkg::PC_RST;
		end else begin
			state <= next_state;
		end
	end

	assign fileReadAddr = state.fileReadAddr;
	assign fileWrite = state.fileWrite;
	assign workingRegister = state.workingRegister;
	assign carry = state.carry;
	assign programCounter = state.pc;
	assign programCounterHighLatch = state.pcHighLatch;
	assign busy = state.busy;
	assign done = state.done;

	property p_rlnc_wrap;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q3 && state.op == rld_pkg::RLD_OP_RLNC)
		|=> (state.result == {$past(state.operand[rld_pkg::MSB-1:0]), $past(state.operand[rld_pkg::MSB])});
	endproperty
	a_rlnc_wrap: assert property (p_rlnc_wrap) else $error("rlnc result wrong");

	property p_rlc_result;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q3 && state.op == rld_pkg::RLD_OP_RLC && !carryLoad)
		|=> (state.result == {$past(state.operand[rld_pkg::MSB-1:0]), $past(state.carry)});
	endproperty
	a_rlc_result: assert property (p_rlc_result) else $error("rlc result wrong");

	property p_rlc_carry;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q3 && state.op == rld_pkg::RLD_OP_RLC)
		##1 !carryLoad |=> (carry == $past(state.carryOut));
	endproperty
	a_rlc_carry: assert property (p_rlc_carry) else $error("rlc carry wrong");

	property p_rlnc_flags;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q4 && state.op == rld_pkg::RLD_OP_RLNC && !carryLoad)
		|=> (carry == $past(carry));
	endproperty
	a_rlnc_flags: assert property (p_rlnc_flags) else $error("rlnc touched carry");

	property p_dest_working;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q4 && state.op != rld_pkg::RLD_OP_NONE
		 && state.op != rld_pkg::RLD_OP_RET && !state.dest)
		|=> (workingRegister == $past(state.result)) && !fileWrite.we;
	endproperty
	a_dest_working: assert property (p_dest_working) else $error("dest 0 misrouted");

	property p_dest_file;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q4 && state.op != rld_pkg::RLD_OP_NONE
		 && state.op != rld_pkg::RLD_OP_RET && state.dest)
		|=> fileWrite.we && fileWrite.data == $past(state.result) && $stable(workingRegister);
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("dest 1 misrouted");

	property p_return_pc;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q4 && state.op == rld_pkg::RLD_OP_RET)
		|=> (programCounter == $past(stackTopValue));
	endproperty
	a_return_pc: assert property (p_return_pc) else $error("return pc wrong");

	property p_latch;
		@(posedge clock) disable iff (rst)
		programCounterLowRead |=> (programCounterHighLatch == $past(state.pc[rld_pkg::PCH_HI:rld_pkg::PCH_LO]));
	endproperty
	a_latch: assert property (p_latch) else $error("high latch not refreshed");

	sequence s_decode_rot;
		state.phase == rld_pkg::RLD_Q1 && instr.valid
		&& instr.word[rld_pkg::OP_HI:rld_pkg::OP_LO] == rld_pkg::OPC_RLNC;
	endsequence

	sequence s_decode_rlc;
		state.phase == rld_pkg::RLD_Q1 && instr.valid
		&& instr.word[rld_pkg::OP_HI:rld_pkg::OP_LO] == rld_pkg::OPC_RLC;
	endsequence

	sequence s_decode_ret;
		state.phase == rld_pkg::RLD_Q1 && instr.valid && instr.word == rld_pkg::OPC_RETURN;
	endsequence

	sequence s_decode_other;
		state.phase == rld_pkg::RLD_Q1 && instr.valid && instr.word != rld_pkg::OPC_RETURN
		&& instr.word[rld_pkg::OP_HI:rld_pkg::OP_LO] != rld_pkg::OPC_RLNC
		&& instr.word[rld_pkg::OP_HI:rld_pkg::OP_LO] != rld_pkg::OPC_RLC;
	endsequence

	property p_one_cycle;
		@(posedge clock) disable iff (rst)
		s_decode_rot |-> ##4 done;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("rotate not one cycle");

	property p_rlc_one_cycle;
		@(posedge clock) disable iff (rst)
		s_decode_rlc |-> ##4 done;
	endproperty
	a_rlc_one_cycle: assert property (p_rlc_one_cycle) else $error("rlc not one cycle");

	property p_return_done;
		@(posedge clock) disable iff (rst)
		s_decode_ret |-> ##4 (done && programCounter == $past(stackTopValue));
	endproperty
	a_return_done: assert property (p_return_done) else $error("return did not complete");

	property p_unknown_idle;
		@(posedge clock) disable iff (rst)
		s_decode_other |-> ##4 (!done && !fileWrite.we && $stable(workingRegister));
	endproperty
	a_unknown_idle: assert property (p_unknown_idle) else $error("unknown opcode acted");

	property p_read_addr;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q1 && instr.valid)
		|=> (fileReadAddr == $past(instr.word[rld_pkg::ADDR_HI:0]));
	endproperty
	a_read_addr: assert property (p_read_addr) else $error("file address not captured");

	property p_operand_read;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q2)
		|=> (state.operand == $past(fileReadData));
	endproperty
	a_operand_read: assert property (p_operand_read) else $error("operand not read in Q2");

	// Phase walk, Q2 through Q4 and back
	sequence s_phase_walk;
		state.phase == rld_pkg::RLD_Q2 ##1 state.phase == rld_pkg::RLD_Q3
		##1 state.phase == rld_pkg::RLD_Q4 ##1 state.phase == rld_pkg::RLD_Q1;
	endsequence

	property p_phase_order;
		@(posedge clock) disable iff (rst)
		state.phase == rld_pkg::RLD_Q1 |=> s_phase_walk;
	endproperty
	a_phase_order: assert property (p_phase_order) else $error("phase order broken");

	property p_write_addr;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q4 && state.dest
		 && (state.op == rld_pkg::RLD_OP_RLNC || state.op == rld_pkg::RLD_OP_RLC))
		|=> (fileWrite.addr == $past(state.addr));
	endproperty
	a_write_addr: assert property (p_write_addr) else $error("write address wrong");

	property p_we_pulse;
		@(posedge clock) disable iff (rst)
		fileWrite.we |=> !fileWrite.we;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");

	property p_done_pulse;
		@(posedge clock) disable iff (rst)
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");

	property p_busy_window;
		@(posedge clock) disable iff (rst)
		(state.phase == rld_pkg::RLD_Q1 && instr.valid) |=> busy [*3] ##1 !busy;
	endproperty
	a_busy_window: assert property (p_busy_window) else $error("busy window wrong");

	property p_latch_hold;
		@(posedge clock) disable iff (rst)
		!programCounterLowRead |=> $stable(programCounterHighLatch);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("high latch moved");

	property p_pc_hold;
		@(posedge clock) disable iff (rst)
		!(state.phase == rld_pkg::RLD_Q4 && state.op == rld_pkg::RLD_OP_RET)
		|=> $stable(programCounter);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved");

	property p_working_hold;
		@(posedge clock) disable iff (rst)
		!(state.phase == rld_pkg::RLD_Q4 && !state.dest
		  && (state.op == rld_pkg::RLD_OP_RLNC || state.op == rld_pkg::RLD_OP_RLC))
		|=> $stable(workingRegister);
	endproperty
	a_working_hold: assert property (p_working_hold) else $error("working register moved");

	property p_carry_hold;
		@(posedge clock) disable iff (rst)
		(!carryLoad && !(state.phase == rld_pkg::RLD_Q4 && state.op == rld_pkg::RLD_OP_RLC))
		|=> $stable(carry);
	endproperty
	a_carry_hold: assert property (p_carry_hold) else $error("carry moved");

endmodule
